// >>> hdl/tmsa_pkg.sv
// Purpose: Shared constants and types of the multiframe sink adapter
// Assumes: 250 MHz core clock, byte-wide payload, label strobe from upstream
// Notes:   Registers are 32-bit words behind a classic Wishbone slave
// What this block does
// - Flag mismatch when accepted label is not 011
// - Recover multiframe phase from label bits 6,7
// - One sequence error drops to out-of-multiframe
// - Four clean frames enter in-multiframe state
// - Fixed timeout out of multiframe declares loss
// - Loss clears on re-entering in-multiframe state
// - Inactive forces server fail, silences causes and events
// - Server fail on mismatch or multiframe loss
// - Mismatch cause only without incoming trail fail
// - Loss cause needs no trail fail, no mismatch
// - Tributaries indexed by L 1-20, sub-index M
// - Bits 6,7 cycle 11, 00, 01, 10
package tmsa_pkg;

  localparam int PAY_DW        = 8;
  localparam int ACCEPT_FRAMES = 5;

  // Register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_EVT  = 8'h08;
  localparam logic [7:0] ADR_MASK = 8'h0C;
  localparam logic [7:0] ADR_TSEL = 8'h10;
  localparam logic [7:0] ADR_TEN  = 8'h14;

  // Field positions and reset values
  localparam int         CTRL_ACT_BIT = 0;
  localparam int         TEN_EN_BIT   = 0;
  localparam int         EV_PLM       = 0;
  localparam int         EV_LOM       = 1;
  localparam int         EV_LOCK      = 2;
  localparam int         EV_UNLOCK    = 3;
  localparam int         EV_W         = 4;
  localparam logic [3:0] MASK_RST     = 4'h0;
  localparam int         LBL_LO       = 3;
  localparam int         LBL_HI       = 5;
  localparam int         MF_LO        = 1;
  localparam int         MF_HI        = 2;

  localparam logic [2:0] LABEL_EXPECTED = 3'h3;
  localparam logic [1:0] MF_FIRST       = 2'h3;
  localparam logic [2:0] ALIGN_FRAMES   = 3'h4;

  // Loss-of-multiframe time and its cycle count
  localparam int unsigned LOM_TIME_US     = 3000;
  localparam int unsigned CLK_KHZ         = 250000;
  localparam int unsigned LOM_CYCLES_DFLT = LOM_TIME_US * (CLK_KHZ / 1000);

  // Tributary numbering
  localparam int         NUM_TRIB    = 140;
  localparam logic [4:0] L_MAX       = 5'h14;
  localparam logic [1:0] TRIB_LARGE  = 2'h0;
  localparam logic [1:0] TRIB_SMALLA = 2'h1;
  localparam logic [7:0] TRIB_BASE_A = 8'h14;
  localparam logic [7:0] TRIB_BASE_B = 8'h50;

  typedef enum logic {MF_HUNT, MF_LOCK} tmsa_mf_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tmsa_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tmsa_wb_rsp_t;

  typedef struct packed {
    logic [1:0] typ;
    logic [1:0] m;
    logic [4:0] l;
  } tmsa_tsel_t;

  typedef struct packed {
    logic [1:0] code;
    logic [2:0] label;
    logic       tsf;
    logic       in_mf;
    logic       lom;
    logic       plm;
  } tmsa_stat_t;

  // Successor code in the multiframe sequence
  function automatic logic [1:0] mf_next(input logic [1:0] c);
    mf_next = c + 2'h1;
  endfunction : mf_next

endpackage : tmsa_pkg

// >>> hdl/tmsa_label_filter.sv
`timescale 1ns/1ps
// Purpose: Persistence filter for the payload label field
// Assumes: One strobe per frame while the label byte is present
// Notes:   Accepted value starts at the expected code
module tmsa_label_filter
  import tmsa_pkg::*;
#(
  parameter int ACCEPT_N = ACCEPT_FRAMES
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  // Label in
  input  wire logic       strobe_i,
  input  wire logic [2:0] label_i,
  // Accepted label
  output logic [2:0]      accepted_o
);

  typedef struct packed {
    logic [2:0] cand;
    logic [3:0] cnt;
    logic [2:0] acc;
  } tmsa_filt_st_t;

  tmsa_filt_st_t q;
  tmsa_filt_st_t d;

  always_comb begin
    d = q;
    if (strobe_i) begin
      if (label_i != q.cand) begin
        d.cand = label_i;
        d.cnt  = 4'h1;
      end else if (q.cnt != 4'(ACCEPT_N)) begin
        d.cnt = q.cnt + 4'h1;
      end
      if (d.cnt == 4'(ACCEPT_N)) begin
        d.acc = label_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q.cand <= LABEL_EXPECTED;
      q.cnt  <= 4'h0;
      q.acc  <= LABEL_EXPECTED;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign accepted_o = q.acc;

  AST_LABEL_PERSIST:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && strobe_i && label_i == q.cand && q.cnt == 4'(ACCEPT_N - 1))
      |=> accepted_o == $past(label_i))
    else $error("label not accepted after persistence");

  AST_LABEL_HOLD:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !(ce_i && strobe_i) |=> $stable(accepted_o))
    else $error("accepted label changed without a strobe");

endmodule : tmsa_label_filter

// >>> hdl/tmsa_sink.sv
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
// Purpose: Label check and multiframe alignment on a payload stream
// Assumes: Same-clock upstream logic, label_strobe_i once per frame
// Notes:   Registers on classic Wishbone, one level interrupt
module tmsa_sink
  import tmsa_pkg::*;
#(
  parameter int          DW         = PAY_DW,
  parameter int unsigned LOM_CYCLES = LOM_CYCLES_DFLT,
  parameter int          ACCEPT_N   = ACCEPT_FRAMES
) (
  // Clock, reset, enable
  input  wire logic          core_clk_i,
  input  wire logic          rstn_i,
  input  wire logic          ce_i,
  // Payload from path termination
  input  wire logic [DW-1:0] payload_data_in_i,
  input  wire logic          payload_valid_i,
  input  wire logic          payload_frame_start_in_i,
  input  wire logic          label_strobe_i,
  input  wire logic          incoming_trail_fail_i,
  // Payload to tributaries
  output logic [DW-1:0]      payload_data_o,
  output logic               payload_valid_o,
  output logic               payload_frame_start_o,
  output logic               multiframe_start_out_o,
  output logic               tributary_server_fail_out_o,
  output logic [NUM_TRIB-1:0] trib_active_o,
  // Fault causes
  output logic               label_mismatch_cause_o,
  output logic               multiframe_loss_cause_o,
  // Register bus and interrupt
  input  wire tmsa_wb_req_t  wb_req_i,
  output tmsa_wb_rsp_t       wb_rsp_o,
  output logic               irq_o
);

  localparam int LW = $clog2(LOM_CYCLES + 1);

  typedef struct packed {
    tmsa_mf_state_t    mf_state;
    logic [1:0]        prev_code;
    logic              prev_vld;
    logic [2:0]        good_cnt;
    logic [LW-1:0]     lom_tmr;
    logic              lom_def;
    logic              plm_def;
    logic              act;
    logic [EV_W-1:0]   evt;
    logic [EV_W-1:0]   mask;
    tmsa_tsel_t        tsel;
    logic [NUM_TRIB-1:0] trib_en;
    logic [DW-1:0]     data;
    logic              valid;
    logic              fs;
    logic              mfs;
    logic              fail;
    logic              plm_cause;
    logic              lom_cause;
    logic              irq;
    logic              ack;
    logic [31:0]       rdat;
  } tmsa_sink_st_t;

  tmsa_sink_st_t q;
  tmsa_sink_st_t d;

  logic [2:0] label_acc;

  // Valid tributary selection
  function automatic logic trib_valid(input tmsa_tsel_t s);
    logic l_ok;
    l_ok = (s.l != 5'h0) && (s.l <= L_MAX);
    if (s.typ == TRIB_LARGE) begin
      trib_valid = l_ok && (s.m == 2'h0);
    end else begin
      trib_valid = l_ok && (s.m != 2'h0) && (s.typ != 2'h3);
    end
  endfunction : trib_valid

  // Flat index of a tributary sink
  function automatic logic [7:0] trib_index(input tmsa_tsel_t s);
    logic [7:0] l0;
    logic [7:0] m0;
    logic [7:0] off;
    l0  = 8'(s.l) - 8'h01;
    m0  = 8'(s.m) - 8'h01;
    off = 8'(l0 * 8'h03) + m0;
    unique case (s.typ)
      TRIB_LARGE:  trib_index = l0;
      TRIB_SMALLA: trib_index = TRIB_BASE_A + off;
      default:     trib_index = TRIB_BASE_B + off;
    endcase
  endfunction : trib_index

  // Byte-lane merge of a write
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input tmsa_wb_req_t r);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (r.sel[i]) begin
        res[8*i +: 8] = r.dat[8*i +: 8];
      end
    end
    wb_merge = res;
  endfunction : wb_merge

  tmsa_label_filter #(
    .ACCEPT_N (ACCEPT_N)
  ) u_label_filter (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .strobe_i   (label_strobe_i),
    .label_i    (payload_data_in_i[LBL_HI:LBL_LO]),
    .accepted_o (label_acc)
  );

  logic [1:0]      code;
  logic            code_ok;
  logic            hit;
  logic            rd_clr;
  logic [31:0]     wval;
  logic [EV_W-1:0] new_ev;
  tmsa_stat_t      stat;

  always_comb begin
    d       = q;
    code    = payload_data_in_i[MF_HI:MF_LO];
    code_ok = q.prev_vld && (code == mf_next(q.prev_code));
    hit     = wb_req_i.cyc && wb_req_i.stb && !q.ack;
    rd_clr  = 1'b0;
    wval    = 32'h0;
    new_ev  = '0;
    stat    = '0;

    // Straight pass of the payload
    d.data = payload_data_in_i;
    d.valid = payload_valid_i;
    d.fs    = payload_frame_start_in_i;
    d.mfs   = 1'b0;

    // Multiframe alignment on bits 6 and 7
    if (label_strobe_i) begin
      d.prev_code = code;
      d.prev_vld  = 1'b1;
      unique case (q.mf_state)
        MF_HUNT: begin
          if (!code_ok) begin
            d.good_cnt = 3'h0;
          end else if (q.good_cnt == ALIGN_FRAMES - 3'h1) begin
            d.mf_state = MF_LOCK;
            d.good_cnt = 3'h0;
          end else begin
            d.good_cnt = q.good_cnt + 3'h1;
          end
        end
        MF_LOCK: begin
          if (!code_ok) begin
            d.mf_state = MF_HUNT;
          end
        end
      endcase
    end

    // Pulse with the frame start of code 11
    if (payload_frame_start_in_i && q.mf_state == MF_LOCK &&
        mf_next(q.prev_code) == MF_FIRST) begin
      d.mfs = 1'b1;
    end

    // Loss timer runs only out of multiframe
    if (d.mf_state == MF_LOCK) begin
      d.lom_tmr = '0;
      d.lom_def = 1'b0;
    end else if (!q.lom_def) begin
      if (q.lom_tmr == LW'(LOM_CYCLES - 1)) begin
        d.lom_def = 1'b1;
      end else begin
        d.lom_tmr = q.lom_tmr + LW'(1);
      end
    end

    // Defects, consequent action and causes
    d.plm_def   = (label_acc != LABEL_EXPECTED);
    d.fail      = !q.act || q.plm_def || q.lom_def;
    d.plm_cause = q.act && q.plm_def && !incoming_trail_fail_i;
    d.lom_cause = q.act && q.lom_def && !incoming_trail_fail_i &&
                  !q.plm_def;

    // Status events, silent while inactive
    new_ev[EV_PLM] = d.plm_cause && !q.plm_cause;
    new_ev[EV_LOM] = d.lom_cause && !q.lom_cause;
    new_ev[EV_LOCK]   = q.act && d.mf_state == MF_LOCK && q.mf_state == MF_HUNT;
    new_ev[EV_UNLOCK] = q.act && d.mf_state == MF_HUNT && q.mf_state == MF_LOCK;

    stat.code  = q.prev_code;
    stat.label = label_acc;
    stat.tsf   = incoming_trail_fail_i;
    stat.in_mf = (q.mf_state == MF_LOCK);
    stat.lom   = q.lom_def;
    stat.plm   = q.plm_def;

    // Register slave, one wait state
    d.ack = hit;
    if (hit && !wb_req_i.we) begin
      unique case (wb_req_i.adr)
        ADR_CTRL: d.rdat = 32'(q.act);
        ADR_STAT: d.rdat = 32'(stat);
        ADR_EVT: begin
          d.rdat = 32'(q.evt);
          rd_clr = 1'b1;
        end
        ADR_MASK: d.rdat = 32'(q.mask);
        ADR_TSEL: d.rdat = 32'(q.tsel);
        ADR_TEN: begin
          d.rdat = 32'h0;
          d.rdat[TEN_EN_BIT + 1] = trib_valid(q.tsel);
          if (trib_valid(q.tsel)) begin
            d.rdat[TEN_EN_BIT] = q.trib_en[trib_index(q.tsel)];
          end
        end
        default: d.rdat = 32'h0;
      endcase
    end
    if (hit && wb_req_i.we) begin
      unique case (wb_req_i.adr)
        ADR_CTRL: begin
          wval  = wb_merge(32'(q.act), wb_req_i);
          d.act = wval[CTRL_ACT_BIT];
        end
        ADR_MASK: begin
          wval   = wb_merge(32'(q.mask), wb_req_i);
          d.mask = wval[EV_W-1:0];
        end
        ADR_TSEL: begin
          wval   = wb_merge(32'(q.tsel), wb_req_i);
          d.tsel = tmsa_tsel_t'(wval[$bits(tmsa_tsel_t)-1:0]);
        end
        ADR_TEN: begin
          wval = wb_merge(32'h0, wb_req_i);
          if (trib_valid(q.tsel)) begin
            d.trib_en[trib_index(q.tsel)] = wval[TEN_EN_BIT];
          end
        end
        default: wval = 32'h0;
      endcase
    end

    // New events win over a read clear
    d.evt = (q.evt & ~{EV_W{rd_clr}}) | new_ev;
    d.irq = |(d.evt & d.mask);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q      <= '0;
      q.mask <= MASK_RST;
      q.fail <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign payload_data_o              = q.data;
  assign payload_valid_o             = q.valid;
  assign payload_frame_start_o       = q.fs;
  assign multiframe_start_out_o      = q.mfs;
  assign tributary_server_fail_out_o = q.fail;
  assign trib_active_o               = q.trib_en;
  assign label_mismatch_cause_o      = q.plm_cause;
  assign multiframe_loss_cause_o     = q.lom_cause;
  assign wb_rsp_o.ack                = q.ack;
  assign wb_rsp_o.dat                = q.rdat;
  assign irq_o                       = q.irq;

  AST_PLM_DEFECT:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ce_i |=> q.plm_def == ($past(label_acc) != LABEL_EXPECTED))
    else $error("label mismatch defect does not follow accepted label");

  AST_UNLOCK_ON_ERROR:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && label_strobe_i && q.mf_state == MF_LOCK && !code_ok)
      |=> q.mf_state == MF_HUNT)
    else $error("sequence error did not leave in-multiframe");

  AST_LOCK_AFTER_FOUR:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (q.mf_state == MF_LOCK && $past(q.mf_state) == MF_HUNT)
      |-> $past(q.good_cnt) == 3'h3 && $past(label_strobe_i && code_ok))
    else $error("in-multiframe entered without four clean frames");

  AST_LOM_TIMEOUT:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      $rose(q.lom_def) |-> $past(q.lom_tmr) == LW'(LOM_CYCLES - 1))
    else $error("multiframe loss declared at wrong time");

  AST_LOM_CLEARED:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      q.mf_state == MF_LOCK |-> !q.lom_def)
    else $error("multiframe loss present while aligned");

  AST_INACTIVE:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && !q.act) |=> tributary_server_fail_out_o &&
      !label_mismatch_cause_o && !multiframe_loss_cause_o)
    else $error("inactive function reports or lets traffic through");

  AST_SERVER_FAIL:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && q.act) |=> tributary_server_fail_out_o ==
      ($past(q.plm_def) || $past(q.lom_def)))
    else $error("server fail does not follow the defects");

  AST_PLM_CAUSE:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ce_i |=> label_mismatch_cause_o ==
      $past(q.act && q.plm_def && !incoming_trail_fail_i))
    else $error("label mismatch cause wrong");

  AST_LOM_CAUSE:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && (q.plm_def || incoming_trail_fail_i)) |=> !multiframe_loss_cause_o)
    else $error("multiframe loss cause not suppressed");

  AST_LOM_CAUSE_SET:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && q.act && q.lom_def && !q.plm_def && !incoming_trail_fail_i)
      |=> multiframe_loss_cause_o)
    else $error("multiframe loss cause not reported");

  AST_FAIL_ON_DEFECT:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && (q.plm_def || q.lom_def)) |=> tributary_server_fail_out_o)
    else $error("server fail missing while a defect is present");

  AST_MF_PULSE:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (ce_i && multiframe_start_out_o) |=> !multiframe_start_out_o)
    else $error("multiframe start longer than one cycle");

  AST_MF_PULSE_FS:
    assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      multiframe_start_out_o |-> payload_frame_start_o && q.mf_state == MF_LOCK)
    else $error("multiframe start off a frame start");

endmodule : tmsa_sink

// >>> dv/tmsa_src_model.sv
// Purpose: Upstream path termination model feeding framed payload
// Assumes: Shares the sink clock; label byte two cycles after frame start
// Notes:   err_i repeats the multiframe code, so each held frame is one break
`timescale 1ns/1ps
module tmsa_src_model
  import tmsa_pkg::*;
#(
  parameter int FLEN = 8
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // Stimulus control
  input  wire logic       err_i,
  input  wire logic [2:0] label_i,
  // Payload out
  output logic [7:0]      data_o,
  output logic            valid_o,
  output logic            fs_o,
  output logic            strobe_o,
  output logic [1:0]      code_o
);
  int pos;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos      <= 0;
      code_o   <= MF_FIRST;
      data_o   <= 8'h00;
      valid_o  <= 1'b0;
      fs_o     <= 1'b0;
      strobe_o <= 1'b0;
    end else begin
      pos      <= (pos == FLEN - 1) ? 0 : pos + 1;
      fs_o     <= (pos == FLEN - 1);
      strobe_o <= (pos == 1);
      valid_o  <= (pos != 4);
      // Code steps 11, 00, 01, 10 unless a break is asked for
      if (pos == FLEN - 1 && !err_i) begin
        code_o <= code_o + 2'h1;
      end
      // Filler changes every cycle so stale data never matches
      data_o <= (pos == 1) ? {2'h2, label_i, code_o, 1'b0} : data_o + 8'h3B;
    end
  end
endmodule : tmsa_src_model

// >>> dv/tmsa_sink_test.sv
// Purpose: Self-checking bench of the multiframe sink adapter
// Assumes: Wishbone master waits for ack; short loss count
// Notes:   Outputs are looked at on the falling edge, where they are settled; read data on the rising edge after ack
`timescale 1ns/1ps
module tmsa_sink_test
  import tmsa_pkg::*;
;
  localparam int FLEN = 8;
  logic               clk;
  logic               rstn;
  logic               ce;
  logic               tsf;
  logic               err;
  logic [2:0]         label;
  tmsa_wb_req_t       req;
  tmsa_wb_rsp_t       rsp;
  logic [7:0]         d;
  logic [7:0]         pdo;
  logic               v, fs, ls, pvo, pfo, mfs, fail, plm_c, lom_c, irq;
  logic [1:0]         code;
  logic [NUM_TRIB-1:0] ta;
  logic [31:0]        rdat;
  int                 failures = 0;
  int                 tests_run = 0;

  tmsa_src_model #(.FLEN(FLEN)) i_tmsa_src_model (.core_clk_i(clk), .rstn_i(rstn),
    .err_i(err), .label_i(label), .data_o(d), .valid_o(v), .fs_o(fs),
    .strobe_o(ls), .code_o(code));

  // Short loss count keeps the run brief
  tmsa_sink #(.LOM_CYCLES(64)) i_tmsa_sink (.core_clk_i(clk), .rstn_i(rstn), .ce_i(ce),
    .payload_data_in_i(d), .payload_valid_i(v), .payload_frame_start_in_i(fs),
    .label_strobe_i(ls), .incoming_trail_fail_i(tsf), .payload_data_o(pdo),
    .payload_valid_o(pvo), .payload_frame_start_o(pfo), .multiframe_start_out_o(mfs),
    .tributary_server_fail_out_o(fail), .trib_active_o(ta),
    .label_mismatch_cause_o(plm_c), .multiframe_loss_cause_o(lom_c),
    .wb_req_i(req), .wb_rsp_o(rsp), .irq_o(irq));

  task automatic results;
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dt);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: dt};
    do begin
      @(negedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    check(n < 50, 1'b1);
    // Ack still stands at this edge; data is taken here
    @(posedge clk);
    rdat = rsp.dat;
    req <= '0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask : rd

  task automatic frames(input int n);
    repeat (n * FLEN) @(posedge clk);
  endtask : frames

  // Ends on the edge that takes the label byte
  task automatic sync;
    do @(negedge clk); while (ls !== 1'b1);
    @(posedge clk);
  endtask : sync

  task automatic chk_out(input logic f, input logic p, input logic l, input logic q);
    @(negedge clk);
    check(fail, f);
    check(plm_c, p);
    check(lom_c, l);
    check(irq, q);
    @(posedge clk);
  endtask : chk_out

  task automatic t_regs;
    chk_out(1'b1, 1'b0, 1'b0, 1'b0);
    check({mfs, |ta, rsp.ack}, 3'h0);
    rd(ADR_CTRL);
    check(rdat, 32'h0);
    rd(ADR_MASK);
    check(rdat, 32'h0);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    rd(8'h40);
    check(rdat, 32'h0);
  endtask : t_regs

  task automatic t_align;
    wb(1'b1, ADR_CTRL, 32'h1);
    frames(8);
    rd(ADR_STAT);
    check(rdat[6:0], {LABEL_EXPECTED, 4'h4});
    chk_out(1'b0, 1'b0, 1'b0, 1'b0);
  endtask : t_align

  task automatic t_stream;
    logic [9:0] prev;
    for (int k = 0; k < 8 * FLEN; k++) begin
      @(negedge clk);
      if (k > 0) check({pdo, pvo, pfo}, prev);
      check(mfs, pfo === 1'b1 && code == MF_FIRST);
      prev = {d, v, fs};
    end
    @(posedge clk);
  endtask : t_stream

  task automatic t_one_err;
    rd(ADR_EVT);
    sync;
    err <= 1'b1;
    repeat (FLEN) @(posedge clk);
    err <= 1'b0;
    // Three clean frames after the break are not yet enough
    frames(3);
    rd(ADR_STAT);
    check(rdat[2], 1'b0);
    rd(ADR_EVT);
    check(rdat[3], 1'b1);
    frames(1);
    rd(ADR_STAT);
    check(rdat[2], 1'b1);
  endtask : t_one_err

  task automatic t_loss;
    sync;
    err <= 1'b1;
    frames(2);
    rd(ADR_STAT);
    check(rdat[2:1], 2'h0);
    frames(8);
    rd(ADR_STAT);
    check(rdat[1], 1'b1);
    chk_out(1'b1, 1'b0, 1'b1, 1'b0);
    tsf <= 1'b1;
    @(posedge clk);
    chk_out(1'b1, 1'b0, 1'b0, 1'b0);
    tsf <= 1'b0;
    err <= 1'b0;
    frames(6);
    rd(ADR_STAT);
    check(rdat[2:1], 2'h2);
    chk_out(1'b0, 1'b0, 1'b0, 1'b0);
  endtask : t_loss

  task automatic t_label;
    wb(1'b1, ADR_MASK, 32'h1);
    rd(ADR_EVT);
    sync;
    label <= 3'h5;
    frames(4);
    rd(ADR_STAT);
    check(rdat[0], 1'b0);
    frames(2);
    rd(ADR_STAT);
    check({rdat[6:4], rdat[0]}, 4'hB);
    chk_out(1'b1, 1'b1, 1'b0, 1'b1);
    rd(ADR_EVT);
    check(rdat[0], 1'b1);
    chk_out(1'b1, 1'b1, 1'b0, 1'b0);
    tsf <= 1'b1;
    @(posedge clk);
    chk_out(1'b1, 1'b0, 1'b0, 1'b0);
    // Deactivate first, so the released trail fail raises no event
    wb(1'b1, ADR_CTRL, 32'h0);
    tsf <= 1'b0;
    label <= LABEL_EXPECTED;
    frames(7);
    rd(ADR_STAT);
    check(rdat[0], 1'b0);
    chk_out(1'b1, 1'b0, 1'b0, 1'b0);
    wb(1'b1, ADR_CTRL, 32'h1);
    chk_out(1'b0, 1'b0, 1'b0, 1'b0);
  endtask : t_label

  task automatic t_trib;
    int tp[3] = '{0, 1, 2};
    int mm[3] = '{0, 1, 3};
    int ll[3] = '{20, 1, 20};
    int ix[3] = '{19, 20, 139};
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, ADR_TSEL, (tp[k] << 7) | (mm[k] << 5) | ll[k]);
      wb(1'b1, ADR_TEN, 32'h1);
      rd(ADR_TEN);
      check(rdat[1:0], 2'h3);
      check(ta[ix[k]], 1'b1);
    end
    check($countones(ta), 3);
    wb(1'b1, ADR_TSEL, 32'h15);
    rd(ADR_TEN);
    check(rdat[1], 1'b0);
  endtask : t_trib

  // Clock enable low must freeze the payload outputs and server fail
  task automatic t_freeze;
    logic [10:0] held;
    ce <= 1'b0;
    @(negedge clk);
    held = {pdo, pvo, pfo, fail};
    repeat (4) begin
      @(negedge clk);
      check({pdo, pvo, pfo, fail}, held);
    end
    @(posedge clk);
    ce <= 1'b1;
  endtask : t_freeze

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    tsf = 1'b0;
    err = 1'b0;
    label = LABEL_EXPECTED;
    req = '0;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_align;
    t_stream;
    t_one_err;
    t_loss;
    t_label;
    t_trib;
    t_freeze;
    results;
  end

  // Whole run is near 550 cycles; this leaves ample margin
  initial begin
    #40000;
    failures++;
    results;
  end
endmodule : tmsa_sink_test
